/* File: hw/dacrb_pkg.sv */
/*
  Constants shared by the readback and status register bank: serial
  frame fields, read-select codes, status bit positions, reset values
  and the frame state enumeration.
  Assumes a 24-bit frame with the command flag in the top bit.
*/
package dacrb_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam int RW_BIT = 23;
  localparam int ADDR_HI_BIT = 22;
  localparam int ADDR_LO_BIT = 21;
  localparam int SEL_MSB = 20;
  localparam int SEL_LSB = 16;
  localparam int CONTROL_REG_SELECT_MSB = 15;
  localparam int CONTROL_REG_SELECT_LSB = 13;
  localparam int SLEW_EN_BIT = 12;
  localparam int RATE_MSB = 6;
  localparam int RATE_LSB = 3;
  localparam int STEP_MSB = 2;
  localparam int STEP_LSB = 0;
  localparam logic [2:0] CONTROL_REG_SELECT_SLEW = 3'h0;
  localparam logic [15:0] SLEW_MASK = 16'h107F;

  // Read-select groups are code[4:2], the channel is code[1:0]
  localparam logic [2:0] GRP_DATA = 3'h0;
  localparam logic [2:0] GRP_CTRL = 3'h1;
  localparam logic [2:0] GRP_GAIN = 3'h2;
  localparam logic [2:0] GRP_OFFS = 3'h3;
  localparam logic [2:0] GRP_CLR = 3'h4;
  localparam logic [2:0] GRP_SLEW = 3'h5;
  localparam logic [4:0] SEL_STATUS = 5'h18;
  localparam logic [4:0] SEL_MAIN = 5'h19;
  localparam logic [4:0] SEL_DCDC = 5'h1A;
  localparam int NUM_CH_REGS = 24;

  localparam int ST_FAULT_LSB = 0;
  localparam int ST_TEMP = 8;
  localparam int ST_RAMP = 9;
  localparam int ST_CRC = 10;
  localparam int ST_TOGGLE = 11;
  localparam int ST_CONV_LSB = 12;
  localparam int MAIN_STATUS_ON_WRITE_ENABLE_BIT = 10;

  localparam logic [15:0] ZERO_RST = 16'h0000;
  localparam logic [15:0] GAIN_RST = 16'hFFFF;
  localparam logic [15:0] OFFS_RST = 16'h8000;
  localparam logic [15:0] DCDC_RST = 16'h0004;

  localparam int CLK_PERIOD_NS = 4;
  localparam int SLEW_BASE_NS = 1000;
  localparam int SLEW_BASE_CYC = SLEW_BASE_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    DACRB_IDLE = 2'b00,
    DACRB_SHIFT = 2'b01,
    DACRB_END = 2'b10
  } dacrb_frame_e;
endpackage

/* File: hw/dacrb_slew_if.sv */
/*
  Carrier between the register bank and one slew stepper channel.
  Assumes both ends run on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface dacrb_slew_if;
  logic en;
  logic [3:0] rate;
  logic [2:0] step;
  logic [15:0] target;
  logic [15:0] code;
  logic active;
  modport ctl (output en, rate, step, target, input code, active);
  modport chan (input en, rate, step, target, output code, active);
endinterface
`default_nettype wire

/* File: hw/dacrb_slew_chan.sv */
/*
  One output channel stepper: walks the output code toward the target
  in steps of 2**step every base*(rate+1) cycles, or jumps when off.
  Assumes configuration from the register bank on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dacrb_slew_chan #(
  parameter int BASE_CYC = dacrb_pkg::SLEW_BASE_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  dacrb_slew_if.chan s
);
  localparam int TW = $clog2(16 * BASE_CYC + 1);

  if (BASE_CYC < 1) begin : g_chk
    $error("BASE_CYC must be at least one");
  end

  logic [15:0] code_q;
  logic [TW-1:0] tick_q;
  wire [TW-1:0] interval = TW'(BASE_CYC * (int'(s.rate) + 1));
  wire [15:0] step_w = 16'h0001 << s.step;
  wire up_w = s.target > code_q;
  wire [15:0] diff_w = up_w ? (s.target - code_q) : (code_q - s.target);
  wire [15:0] move_w = (diff_w < step_w) ? diff_w : step_w;
  wire tick_w = tick_q >= (interval - TW'(1));

  assign s.code = code_q;
  assign s.active = s.en && (code_q != s.target);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      code_q <= 16'h0000;
      tick_q <= '0;
    end else if (ce) begin
      if (!s.en) begin
        code_q <= s.target;
        tick_q <= '0;
      end else if (code_q == s.target) begin
        tick_q <= '0;
      end else if (tick_w) begin
        code_q <= up_w ? code_q + move_w : code_q - move_w;
        tick_q <= '0;
      end else begin
        tick_q <= tick_q + TW'(1);
      end
    end
  end

  direct_jump_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && !s.en |=> code_q == $past(s.target))
    else $error("disabled channel did not jump to target");

  step_bound_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && s.en && code_q != s.target |=>
      ((code_q >= $past(code_q)) ? code_q - $past(code_q)
        : $past(code_q) - code_q) <= $past(step_w))
    else $error("slew step larger than programmed");
endmodule
`default_nettype wire

/* File: hw/dacrb_regs.sv */
/*
  Serial register bank of a quad current-output converter: write
  decode, slew control registers, two-frame readback, status word with
  fault flags, status-on-write and the open-drain fault pin.
  Assumes sclk, sync_n, sdin, straps and analog flags are asynchronous
  to mclk; crc_fail is a one-cycle pulse from logic on mclk.
  // What this block does
  // - CONTROL_REG_SELECT 000 writes channel slew register
  // - Per-channel slew enable in D12
  // - Rate D6-D3, step D2-D0, rest ignored
  // - Slew off: new code applied at once
  // - Top frame bit set requests a read
  // - Decode device address and read select
  // - Next frame shifts selected register out
  // - Codes 0-7: data, control registers
  // - Codes 8-15: gain, offset registers
  // - Codes 16-23: clear code, slew registers
  // - 24 status, 25 main, 26 dc-dc
  // - Status read-only except toggle bit
  // - Status-on-write drives status every frame
  // - Else status via normal readback
  // - Output faults D-A in D3-D0
  // - Temp, ramp, CRC, toggle, converter bits
  // - Current mode converter flag sets fault
  // - Voltage mode converter flag, no pin
  // - Toggle bit writable and read back
  // - Fault pin: compliance, CRC or temperature
*/
`timescale 1ns/1ps
`default_nettype none
module dacrb_regs #(
  parameter int SLEW_BASE_CYC = dacrb_pkg::SLEW_BASE_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdin,
  input wire logic device_addr_hi,
  input wire logic device_addr_lo,
  input wire logic [3:0] comp_fault,
  input wire logic [3:0] conv_fail,
  input wire logic [3:0] volt_mode,
  input wire logic over_temp,
  input wire logic crc_fail,
  output logic sdo,
  output logic fault_n_o,
  output logic fault_n_oe,
  output logic [63:0] dac_code
);
  localparam int SW = 18;
  localparam int FB = dacrb_pkg::FRAME_BITS;

  if (SLEW_BASE_CYC < 1) begin : g_chk
    $error("SLEW_BASE_CYC must be at least one");
  end

  // Two-stage synchronisers; stage one feeds stage two only
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic sclk_d_q;
  logic sync_n_d_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= 18'h30000;
      sync2_q <= 18'h30000;
      sclk_d_q <= 1'b1;
      sync_n_d_q <= 1'b1;
    end else if (ce) begin
      sync1_q <= {sclk, sync_n, sdin, device_addr_hi, device_addr_lo,
                  comp_fault, conv_fail, volt_mode, over_temp};
      sync2_q <= sync1_q;
      sclk_d_q <= sync2_q[17];
      sync_n_d_q <= sync2_q[16];
    end
  end

  wire sclk_s = sync2_q[17];
  wire sync_n_s = sync2_q[16];
  wire sdin_s = sync2_q[15];
  wire [1:0] addr_s = sync2_q[14:13];
  wire [3:0] comp_s = sync2_q[12:9];
  wire [3:0] conv_s = sync2_q[8:5];
  wire temp_s = sync2_q[0];
  wire [3:0] volt_w = sync2_q[4:1];
  wire sclk_fall = sclk_d_q && !sclk_s;
  wire frame_start = sync_n_d_q && !sync_n_s;

  // Frame receiver
  dacrb_pkg::dacrb_frame_e state_q;
  logic [FB-1:0] in_sr_q;
  logic [FB-1:0] out_sr_q;
  logic [dacrb_pkg::CNT_W-1:0] cnt_q;
  logic sdo_q;

  logic [15:0] regs_q [0:dacrb_pkg::NUM_CH_REGS-1];
  logic [15:0] main_q;
  logic [15:0] dcdc_q;
  logic toggle_q;
  logic crc_q;
  logic ramp_q;
  logic pend_q;
  logic [4:0] pend_sel_q;
  logic fault_oe_q;
  logic [63:0] dac_code_q;

  wire commit = state_q == dacrb_pkg::DACRB_END;
  wire rw_w = in_sr_q[dacrb_pkg::RW_BIT];
  wire match_w = {in_sr_q[dacrb_pkg::ADDR_HI_BIT],
                  in_sr_q[dacrb_pkg::ADDR_LO_BIT]} == addr_s;
  wire [4:0] in_sel = in_sr_q[dacrb_pkg::SEL_MSB:dacrb_pkg::SEL_LSB];
  wire [2:0] control_reg_select_w = in_sr_q[dacrb_pkg::CONTROL_REG_SELECT_MSB:dacrb_pkg::CONTROL_REG_SELECT_LSB];
  wire rd_req = commit && match_w && rw_w;
  wire wr_req = commit && match_w && !rw_w;
  wire slew_wr = (in_sel[4:2] == dacrb_pkg::GRP_CTRL
                  && control_reg_select_w == dacrb_pkg::CONTROL_REG_SELECT_SLEW)
                 || in_sel[4:2] == dacrb_pkg::GRP_SLEW;
  wire [4:0] wr_idx = slew_wr ? {dacrb_pkg::GRP_SLEW, in_sel[1:0]}
                              : in_sel;
  wire [15:0] wr_val = slew_wr ? (in_sr_q[15:0] & dacrb_pkg::SLEW_MASK)
                               : in_sr_q[15:0];
  wire wr_ch = wr_req && (int'(wr_idx) < dacrb_pkg::NUM_CH_REGS);
  wire wr_toggle = wr_req && wr_idx == dacrb_pkg::SEL_STATUS;
  wire wr_main = wr_req && wr_idx == dacrb_pkg::SEL_MAIN;
  wire wr_dcdc = wr_req && wr_idx == dacrb_pkg::SEL_DCDC;

  // Status word and fault pin
  // A converter that cannot hold compliance in current mode also
  // marks the channel faulty; in voltage mode it only sets its flag.
  wire [3:0] chan_fault = comp_s | (conv_s & ~volt_w);
  wire fault_any = (|chan_fault) || crc_q || temp_s;
  wire [15:0] status_w = {conv_s, toggle_q, crc_q, ramp_q, temp_s,
                          4'h0, chan_fault};
  wire status_on_write_enable = main_q[dacrb_pkg::MAIN_STATUS_ON_WRITE_ENABLE_BIT];

  // Read mux for the register picked by the previous read request
  wire [15:0] rd_data =
    (pend_sel_q == dacrb_pkg::SEL_STATUS) ? status_w :
    (pend_sel_q == dacrb_pkg::SEL_MAIN) ? main_q :
    (pend_sel_q == dacrb_pkg::SEL_DCDC) ? dcdc_q :
    (int'(pend_sel_q) < dacrb_pkg::NUM_CH_REGS) ? regs_q[pend_sel_q] :
    16'h0000;
  // With status-on-write set, ordinary readback is given up for status
  wire [4:0] out_sel = status_on_write_enable ? dacrb_pkg::SEL_STATUS : pend_sel_q;
  wire [15:0] out_data = status_on_write_enable ? status_w : rd_data;
  wire out_valid = status_on_write_enable || pend_q;
  wire [FB-1:0] out_word = out_valid ? {1'b0, addr_s, out_sel, out_data}
                                     : 24'h000000;
  wire status_out = frame_start && out_valid
                    && out_sel == dacrb_pkg::SEL_STATUS;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q <= dacrb_pkg::DACRB_IDLE;
      in_sr_q <= 24'h000000;
      out_sr_q <= 24'h000000;
      cnt_q <= 5'h00;
      sdo_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        dacrb_pkg::DACRB_IDLE: begin
          if (frame_start) begin
            out_sr_q <= out_word;
            sdo_q <= out_word[FB-1];
            cnt_q <= 5'h00;
            state_q <= dacrb_pkg::DACRB_SHIFT;
          end
        end
        dacrb_pkg::DACRB_SHIFT: begin
          if (sync_n_s) begin
            state_q <= (int'(cnt_q) == FB) ? dacrb_pkg::DACRB_END
                                           : dacrb_pkg::DACRB_IDLE;
          end else if (sclk_fall) begin
            in_sr_q <= {in_sr_q[FB-2:0], sdin_s};
            out_sr_q <= {out_sr_q[FB-2:0], 1'b0};
            sdo_q <= out_sr_q[FB-2];
            if (int'(cnt_q) < FB) begin
              cnt_q <= cnt_q + 5'h01;
            end
          end
        end
        dacrb_pkg::DACRB_END: begin
          state_q <= dacrb_pkg::DACRB_IDLE;
        end
        default: begin
          state_q <= dacrb_pkg::DACRB_IDLE;
        end
      endcase
    end
  end

  // Pending read; a new request in the commit cycle replaces the old
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pend_q <= 1'b0;
      pend_sel_q <= 5'h00;
    end else if (ce) begin
      if (rd_req) begin
        pend_q <= 1'b1;
        pend_sel_q <= in_sel;
      end else if (frame_start && state_q == dacrb_pkg::DACRB_IDLE) begin
        pend_q <= 1'b0;
      end
    end
  end

  function automatic logic [15:0] rst_val(input int idx);
    if (idx / 4 == int'(dacrb_pkg::GRP_GAIN)) begin
      return dacrb_pkg::GAIN_RST;
    end else if (idx / 4 == int'(dacrb_pkg::GRP_OFFS)) begin
      return dacrb_pkg::OFFS_RST;
    end
    return dacrb_pkg::ZERO_RST;
  endfunction

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < dacrb_pkg::NUM_CH_REGS; i++) begin
        regs_q[i] <= rst_val(i);
      end
    end else if (ce && wr_ch) begin
      regs_q[wr_idx] <= wr_val;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      main_q <= dacrb_pkg::ZERO_RST;
      dcdc_q <= dacrb_pkg::DCDC_RST;
      toggle_q <= 1'b0;
    end else if (ce) begin
      if (wr_main) begin
        main_q <= in_sr_q[15:0];
      end
      if (wr_dcdc) begin
        dcdc_q <= in_sr_q[15:0];
      end
      if (wr_toggle) begin
        toggle_q <= in_sr_q[dacrb_pkg::ST_TOGGLE];
      end
    end
  end

  // CRC flag holds until a frame that loads status for shifting out starts; a new error wins
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      crc_q <= 1'b0;
    end else if (ce) begin
      if (crc_fail) begin
        crc_q <= 1'b1;
      end else if (status_out && state_q == dacrb_pkg::DACRB_IDLE) begin
        crc_q <= 1'b0;
      end
    end
  end

  // Slew steppers, one per channel
  logic [3:0] act_w;
  logic [15:0] code_w [0:3];

  for (genvar i = 0; i < 4; i++) begin : g_ch
    localparam int SI = int'(dacrb_pkg::GRP_SLEW) * 4 + i;
    dacrb_slew_if sif ();
    assign sif.en = regs_q[SI][dacrb_pkg::SLEW_EN_BIT];
    assign sif.rate = regs_q[SI][dacrb_pkg::RATE_MSB:dacrb_pkg::RATE_LSB];
    assign sif.step = regs_q[SI][dacrb_pkg::STEP_MSB:dacrb_pkg::STEP_LSB];
    assign sif.target = regs_q[i];
    assign act_w[i] = sif.active;
    assign code_w[i] = sif.code;
    dacrb_slew_chan #(
      .BASE_CYC(SLEW_BASE_CYC)
    ) u_chan (
      .mclk(mclk),
      .resetn(resetn),
      .ce(ce),
      .s(sif.chan)
    );
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ramp_q <= 1'b0;
      fault_oe_q <= 1'b0;
      dac_code_q <= 64'h0000000000000000;
    end else if (ce) begin
      ramp_q <= |act_w;
      fault_oe_q <= fault_any;
      dac_code_q <= {code_w[3], code_w[2], code_w[1], code_w[0]};
    end
  end

  assign sdo = sdo_q;
  assign fault_n_o = 1'b0;
  assign fault_n_oe = fault_oe_q;
  assign dac_code = dac_code_q;

  sequence rd_commit_s;
    ce && rd_req;
  endsequence

  sequence next_start_s;
    ce && frame_start && state_q == dacrb_pkg::DACRB_IDLE && !status_on_write_enable
      && pend_q;
  endsequence

  read_pend_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_commit_s |=> pend_q && pend_sel_q == $past(in_sel))
    else $error("read request not latched");

  readback_data_a: assert property (@(posedge mclk) disable iff (!resetn)
    rd_commit_s ##1 (!rd_req && ce) [*1] ##[0:1000] next_start_s
      |=> out_sr_q[15:0] == $past(rd_data) && out_sr_q[23] == 1'b0)
    else $error("readback word not loaded at next frame");

  status_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && frame_start && state_q == dacrb_pkg::DACRB_IDLE && status_on_write_enable
      |=> out_sr_q[15:0] == $past(status_w)
          && out_sr_q[20:16] == dacrb_pkg::SEL_STATUS)
    else $error("status not driven during write frame");

  slew_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && wr_req && slew_wr |=>
      regs_q[$past(wr_idx)] == ($past(in_sr_q[15:0])
                                & dacrb_pkg::SLEW_MASK))
    else $error("slew register write wrong");

  status_ro_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && wr_toggle |=> toggle_q == $past(in_sr_q[11])
      && main_q == $past(main_q) && dcdc_q == $past(dcdc_q))
    else $error("status write touched more than toggle");

  conv_current_a: assert property (@(posedge mclk) disable iff (!resetn)
    conv_s[0] && !volt_w[0] |-> status_w[0] && status_w[12])
    else $error("current mode converter flag lacks fault");

  conv_voltage_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && conv_s[0] && volt_w[0] && !comp_s[0] && !crc_q && !temp_s
      && !(|(chan_fault[3:1]))
      |=> !fault_n_oe)
    else $error("voltage mode converter flag drove fault pin");

  fault_pin_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce && fault_any |=> fault_n_oe && !fault_n_o)
    else $error("fault pin not asserted");

  ramp_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
    ce |=> status_w[dacrb_pkg::ST_RAMP] == $past(|act_w))
    else $error("ramp flag does not follow slewing");
endmodule
`default_nettype wire

/* File: bench/dacrb_host.sv */
/*
  Serial host model for the register bank: 24-bit frames, MSB first,
  sclk period 48 ns, sclk parked high outside frames.
  Assumes the device samples sdin on sclk falling edges and presents
  each sdo bit before the next falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module dacrb_host (
  output logic sclk,
  output logic sync_n,
  output logic sdin,
  input wire logic sdo
);
  initial begin
    sclk = 1'b1;
    sync_n = 1'b1;
    sdin = 1'b0;
  end

  // A read answer only shows in the following frame
  task automatic xfer(input logic [23:0] w, output logic [23:0] r);
    sync_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      sdin = w[i];
      #24;
      r[i] = sdo;
      sclk = 1'b0;
      #24;
      sclk = 1'b1;
    end
    sync_n = 1'b1;
    // Released line flips so a stale bit can never look valid
    sdin = ~sdin;
    #24;
  endtask
endmodule
`default_nettype wire

/* File: bench/test_dac_readback_status_regs.sv */
/*
  Self-checking bench for the readback and status register bank.
  Assumes the straps select device address 2 and a shortened slew base
  count of 4 mclk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module test_dac_readback_status_regs;
  logic mclk, resetn, sclk, sync_n, sdin, sdo, fault_n_o, fault_n_oe;
  logic over_temp, crc_fail;
  logic [3:0] comp_fault, conv_fail, volt_mode;
  logic [63:0] dac_code;
  int bad_count = 0;
  int checks = 0;

  dacrb_regs #(.SLEW_BASE_CYC(4)) i_dut (
    .mclk(mclk), .resetn(resetn), .ce(1'b1), .sclk(sclk),
    .sync_n(sync_n), .sdin(sdin), .device_addr_hi(1'b1),
    .device_addr_lo(1'b0), .comp_fault(comp_fault),
    .conv_fail(conv_fail), .volt_mode(volt_mode),
    .over_temp(over_temp), .crc_fail(crc_fail), .sdo(sdo),
    .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe), .dac_code(dac_code)
  );
  dacrb_host i_host (.sclk(sclk), .sync_n(sync_n), .sdin(sdin), .sdo(sdo));

  always #2 mclk = ~mclk;

  task automatic end_sim;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      bad_count++;
    end
  endtask

  function automatic logic [23:0] word(input logic [4:0] s,
                                       input logic [15:0] v);
    return {3'b010, s, v};
  endfunction

  function automatic logic [15:0] rst_val(input logic [4:0] s);
    if (s[4:2] == dacrb_pkg::GRP_GAIN) return dacrb_pkg::GAIN_RST;
    if (s[4:2] == dacrb_pkg::GRP_OFFS) return dacrb_pkg::OFFS_RST;
    if (s == dacrb_pkg::SEL_DCDC) return dacrb_pkg::DCDC_RST;
    return dacrb_pkg::ZERO_RST;
  endfunction

  task automatic frame(input logic rw, input logic [4:0] s,
                       input logic [15:0] d, output logic [23:0] r);
    i_host.xfer({rw, 2'b10, s, d}, r);
  endtask

  // Second frame asks for an unmapped code so no status read is left over
  task automatic st(output logic [23:0] r);
    logic [23:0] x;
    frame(1'b1, dacrb_pkg::SEL_STATUS, 16'h0000, x);
    frame(1'b1, 5'h1F, 16'h0000, r);
  endtask

  task automatic t_reset_map;
    logic [23:0] r;
    logic [4:0] s;
    frame(1'b1, 5'h00, 16'hFFFF, r);
    for (int i = 1; i <= 28; i++) begin
      s = 5'(i - 1);
      frame(1'b1, 5'(i), 16'hFFFF, r);
      if (i < 28)
        check(r, word(s, rst_val(s)));
      else
        check(r[15:0], 16'h0000);
    end
  endtask

  task automatic t_slew_regs;
    logic [23:0] r;
    frame(1'b0, 5'h05, 16'h1FFF, r);
    frame(1'b0, 5'h16, 16'hEFFF, r);
    frame(1'b1, 5'h14, 16'h0000, r);
    frame(1'b1, 5'h15, 16'h0000, r);
    check(r, word(5'h14, 16'h0000));
    frame(1'b1, 5'h16, 16'h0000, r);
    check(r, word(5'h15, 16'h107F));
    frame(1'b1, 5'h1F, 16'h0000, r);
    check(r, word(5'h16, 16'h007F));
    frame(1'b0, 5'h06, 16'h2ABC, r);
    frame(1'b1, 5'h06, 16'h0000, r);
    frame(1'b1, 5'h16, 16'h0000, r);
    check(r, word(5'h06, 16'h2ABC));
    frame(1'b1, 5'h1F, 16'h0000, r);
    check(r, word(5'h16, 16'h007F));
  endtask

  task automatic t_jump;
    logic [23:0] r;
    frame(1'b0, 5'h00, 16'h1234, r);
    frame(1'b0, 5'h03, 16'hBEEF, r);
    repeat (4) @(negedge mclk);
    check(dac_code[15:0], 16'h1234);
    check(dac_code[63:48], 16'hBEEF);
    frame(1'b1, 5'h03, 16'h0000, r);
    frame(1'b1, 5'h1F, 16'h0000, r);
    check(r, word(5'h03, 16'hBEEF));
  endtask

  // Rate 1, step 1: two codes every eight cycles
  task automatic t_ramp;
    logic [23:0] r;
    frame(1'b0, 5'h14, 16'h1009, r);
    frame(1'b0, 5'h00, 16'h1634, r);
    @(negedge mclk);
    check(dac_code[15:0] < 16'h1634, 1'b1);
    st(r);
    check(r[9], 1'b1);
    repeat (1700) @(negedge mclk);
    check(dac_code[15:0] < 16'h1634 && dac_code[15:0] > 16'h1234,
          1'b1);
    check(dac_code[0], 1'b0);
    repeat (2500) @(negedge mclk);
    check(dac_code[15:0], 16'h1634);
    st(r);
    check(r, word(dacrb_pkg::SEL_STATUS, 16'h0000));
  endtask

  task automatic t_status;
    logic [23:0] r;
    @(negedge mclk);
    conv_fail = 4'h1;
    volt_mode = 4'h1;
    repeat (10) @(negedge mclk);
    check(fault_n_oe, 1'b0);
    st(r);
    check(r, word(dacrb_pkg::SEL_STATUS, 16'h1000));
    volt_mode = 4'h0;
    repeat (10) @(negedge mclk);
    check(fault_n_oe, 1'b1);
    st(r);
    check(r, word(dacrb_pkg::SEL_STATUS, 16'h1001));
    frame(1'b0, dacrb_pkg::SEL_STATUS, 16'hFFFF, r);
    conv_fail = 4'h0;
    comp_fault = 4'h8;
    over_temp = 1'b1;
    st(r);
    check(r, word(dacrb_pkg::SEL_STATUS, 16'h0908));
    check(fault_n_oe, 1'b1);
    comp_fault = 4'h0;
    over_temp = 1'b0;
    repeat (10) @(negedge mclk);
    check(fault_n_oe, 1'b0);
    crc_fail = 1'b1;
    @(negedge mclk);
    crc_fail = 1'b0;
    repeat (10) @(negedge mclk);
    check(fault_n_oe, 1'b1);
    st(r);
    check(r, word(dacrb_pkg::SEL_STATUS, 16'h0C00));
    st(r);
    check(r, word(dacrb_pkg::SEL_STATUS, 16'h0800));
    check(fault_n_oe, 1'b0);
  endtask

  task automatic t_statwr;
    logic [23:0] r;
    frame(1'b0, dacrb_pkg::SEL_MAIN, 16'h0400, r);
    frame(1'b0, 5'h02, 16'h4321, r);
    check(r[15:0], 16'h0800);
    frame(1'b0, dacrb_pkg::SEL_MAIN, 16'h0000, r);
    check(r[15:0], 16'h0800);
    check(dac_code[47:32], 16'h4321);
    frame(1'b0, 5'h02, 16'h0000, r);
    check(r, 24'h000000);
  endtask

  task automatic t_addr;
    logic [23:0] r;
    i_host.xfer({3'b001, 5'h03, 16'h5555}, r);
    i_host.xfer({3'b101, 5'h08, 16'h0000}, r);
    frame(1'b1, 5'h1F, 16'h0000, r);
    check(r, 24'h000000);
    check(dac_code[63:48], 16'hBEEF);
    check(fault_n_o, 1'b0);
  endtask

  initial begin
    mclk = 1'b0;
    resetn = 1'b0;
    comp_fault = 4'h0;
    conv_fail = 4'h0;
    volt_mode = 4'h0;
    over_temp = 1'b0;
    crc_fail = 1'b0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    resetn = 1'b1;
    repeat (4) @(negedge mclk);
    check(fault_n_oe, 1'b0);
    t_reset_map();
    t_slew_regs();
    t_jump();
    t_ramp();
    t_status();
    t_statwr();
    t_addr();
    end_sim();
  end

  initial begin
    #300000;
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
